// file: rtl/threshold_copy_waitentry_decode.sv
module threshold_copy_waitentry_decode #(
  parameter int REG_WIDTH = 16,
  parameter int ADDR_WIDTH = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // instruction from code memory
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  // drive rights and bootstrap
  input wire logic [15:0] driveRight,
  input wire logic bootstrapLoad,
  input wire logic [4:0] bootstrapLevel,
  // core register file access
  input wire logic [REG_WIDTH-1:0] sourceData,
  // jump pointers
  input wire logic [ADDR_WIDTH-1:0] jumpPointerFirst,
  input wire logic [ADDR_WIDTH-1:0] jumpPointerSecond,
  // wait phase
  input wire logic waitActive,
  input wire logic [15:0] flags,
  input wire logic [3:0] terminalCount,
  input wire logic startPin,
  input wire logic [5:0] shortcutFeedback,
  input wire logic aluDone,
  input wire logic boostHigh,
  input wire logic [5:0] currentFeedback,
  input wire logic ownCurrent,
  // comparator thresholds, three bits per comparator
  output logic [47:0] thresholdLevels,
  // register move
  output logic [4:0] sourceSelect,
  output logic [4:0] destSelect,
  output logic [REG_WIDTH-1:0] destData,
  output logic destWrite,
  // jump out of wait
  output logic jumpTaken,
  output logic [ADDR_WIDTH-1:0] jumpAddress,
  output logic [4:0] rowEnabled
);
  typedef struct packed {
    logic [47:0] thresholds;
    logic [4:0] srcSel;
    logic [4:0] dstSel;
    logic [REG_WIDTH-1:0] dstData;
    logic dstWrite;
    logic pendingMove;
    logic [4:0] enabled;
    logic [29:0] conds;
    logic [4:0] jumpSel;
    logic jump;
    logic [ADDR_WIDTH-1:0] jumpAddr;
    logic startMeta;
    logic startSync;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [4:0] rowMet;

  // one evaluator per row so every row is tested every cycle
  for (genvar r = 0; r < decode_pkg::ROWS; r++) begin : g_row
    wait_condition_eval u_eval (
      .cond(cur.conds[6*r +: 6]),
      .flags(flags),
      .terminalCount(terminalCount),
      .startLevel(cur.startSync),
      .shortcutFeedback(shortcutFeedback),
      .aluDone(aluDone),
      .boostHigh(boostHigh),
      .currentFeedback(currentFeedback),
      .ownCurrent(ownCurrent),
      .met(rowMet[r])
    );
  end

  logic isThresh;
  logic isMove;
  logic isFar;
  logic [3:0] selCode;
  logic [2:0] rowCode;
  always_comb begin
    isThresh = instrValid
      && instrWord[15:7] == decode_pkg::THRESH_OPCODE;
    isMove = instrValid && instrWord[15:13] == decode_pkg::MOVE_OPCODE
      && instrWord[2:0] == decode_pkg::MOVE_TAIL;
    isFar = instrValid
      && instrWord[15:10] == decode_pkg::FAR_ENTRY_OPCODE;
    selCode = instrWord[decode_pkg::SEL_MSB:decode_pkg::SEL_LSB];
    rowCode = instrWord[decode_pkg::ROW_MSB:decode_pkg::ROW_LSB];
  end

  always_comb begin
    next_cur = cur;
    next_cur.startMeta = startPin;
    next_cur.startSync = cur.startMeta;
    next_cur.dstWrite = 1'b0;
    next_cur.jump = 1'b0;
    // bootstrap mode drives high-side source levels; instruction wins
    // in the same cycle since it was issued later by the core
    if (bootstrapLoad) begin
      for (int d = 0; d < 5; d++) begin
        if (bootstrapLevel[d]) begin
          next_cur.thresholds[3*(2*d+1) +: 3] = decode_pkg::THRESH_RESET;
        end
      end
    end
    // select code indexes the comparator directly: 0-9 high pairs,
    // 10-15 low-side drains, so the index is the code itself
    if (isThresh && driveRight[selCode]) begin
      next_cur.thresholds[3*selCode +: 3] = instrWord[2:0];
    end
    // move: read select first, write data the next cycle
    if (isMove) begin
      next_cur.srcSel = instrWord[decode_pkg::MOVE_SRC_MSB:
        decode_pkg::MOVE_SRC_LSB];
      next_cur.dstSel = instrWord[decode_pkg::MOVE_DST_MSB:
        decode_pkg::MOVE_DST_LSB];
      next_cur.pendingMove = 1'b1;
    end else begin
      next_cur.pendingMove = 1'b0;
    end
    if (cur.pendingMove) begin
      next_cur.dstData = sourceData;
      next_cur.dstWrite = 1'b1;
    end
    if (isFar && rowCode <= decode_pkg::LAST_ROW) begin
      next_cur.conds[6*rowCode +: 6] = instrWord[5:0];
      next_cur.jumpSel[rowCode] = instrWord[decode_pkg::JUMP_BIT];
      next_cur.enabled[rowCode] = 1'b1;
    end
    // lowest row wins when several conditions hold at once
    if (waitActive) begin
      for (int r = decode_pkg::ROWS - 1; r >= 0; r--) begin
        if (cur.enabled[r] && rowMet[r]) begin
          next_cur.jump = 1'b1;
          next_cur.jumpAddr = cur.jumpSel[r] ? jumpPointerSecond
            : jumpPointerFirst;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  always_comb begin
    thresholdLevels = cur.thresholds;
    sourceSelect = cur.srcSel;
    destSelect = cur.dstSel;
    destData = cur.dstData;
    destWrite = cur.dstWrite;
    jumpTaken = cur.jump;
    jumpAddress = cur.jumpAddr;
    rowEnabled = cur.enabled;
  end
endmodule

// file: rtl/decode_pkg.sv
// Function
// - threshold instruction updates level of the one selected feedback comparator
// - threshold changes only when core holds drive right for that output
// - bootstrap init mode may also set high-side source thresholds
// - select codes 0 to 9 pair drain then source for high drivers 1-5
// - select codes 10 to 15 pick low driver 1-6 drain comparators
// - 3-bit threshold code picks one of eight levels, 000 first
// - threshold opcode bits 15:7 = 001011111, select 6:3, level 2:0
// - move instruction copies source core register into destination register
// - move opcode bits 15:13 = 101, bits 2:0 = 000, source above destination
// - far wait entry instruction initialises or overwrites the chosen row
// - wait table has five rows of condition and jump pointer choice
// - all five row conditions are evaluated concurrently
// - enabled true row jumps to address in its jump pointer register
// - far entry jump operand selects a jump pointer, not a core register
// - codes 0-15 test flag low, 16-31 flag high, index in low bits
// - codes 32-35 terminal counts, 36/37 start, 38-46 shortcut tests
// - code 47 ALU done, 48 boost high, 49 boost low
// - codes 50-55 current feedbacks high, 56-61 the same low
// - code 62 own current high, 63 own current low
// - jump selector is one bit: 0 first pointer, 1 second
// - far entry: bits 15:10 fixed, jump bit 9, row 8:6, condition 5:0
package decode_pkg;
  localparam logic [8:0] THRESH_OPCODE = 9'h05f;
  localparam logic [2:0] MOVE_OPCODE = 3'h5;
  localparam logic [2:0] MOVE_TAIL = 3'h0;
  localparam logic [5:0] FAR_ENTRY_OPCODE = 6'h04;
  localparam int SEL_MSB = 6;
  localparam int SEL_LSB = 3;
  localparam int MOVE_SRC_MSB = 12;
  localparam int MOVE_SRC_LSB = 8;
  localparam int MOVE_DST_MSB = 7;
  localparam int MOVE_DST_LSB = 3;
  localparam int JUMP_BIT = 9;
  localparam int ROW_MSB = 8;
  localparam int ROW_LSB = 6;
  localparam int ROWS = 5;
  localparam int COMPARATORS = 16;
  localparam int HIGH_COMPARATORS = 10;
  localparam logic [2:0] LAST_ROW = 3'h4;
  localparam logic [2:0] THRESH_RESET = 3'h0;
  localparam logic [5:0] COND_TC_BASE = 6'h20;
  localparam logic [5:0] COND_START_LOW = 6'h24;
  localparam logic [5:0] COND_START_HIGH = 6'h25;
  localparam logic [5:0] COND_SC_BASE = 6'h26;
  localparam logic [5:0] COND_ALU_DONE = 6'h2f;
  localparam logic [5:0] COND_BOOST_HIGH = 6'h30;
  localparam logic [5:0] COND_BOOST_LOW = 6'h31;
  localparam logic [5:0] COND_CUR_HIGH_BASE = 6'h32;
  localparam logic [5:0] COND_CUR_LOW_BASE = 6'h38;
  localparam logic [5:0] COND_OWN_HIGH = 6'h3e;
  localparam logic [5:0] COND_OWN_LOW = 6'h3f;
endpackage

// file: rtl/wait_condition_eval.sv
module wait_condition_eval (
  // condition code
  input wire logic [5:0] cond,
  // live status
  input wire logic [15:0] flags,
  input wire logic [3:0] terminalCount,
  input wire logic startLevel,
  input wire logic [5:0] shortcutFeedback,
  input wire logic aluDone,
  input wire logic boostHigh,
  input wire logic [5:0] currentFeedback,
  input wire logic ownCurrent,
  // result
  output logic met
);
  logic [5:0] off;
  always_comb begin
    off = 6'h00;
    met = 1'b0;
    if (cond < decode_pkg::COND_TC_BASE) begin
      met = flags[cond[3:0]] == cond[4];
    end else if (cond < decode_pkg::COND_START_LOW) begin
      off = cond - decode_pkg::COND_TC_BASE;
      met = terminalCount[off[1:0]];
    end else if (cond == decode_pkg::COND_START_LOW) begin
      met = !startLevel;
    end else if (cond == decode_pkg::COND_START_HIGH) begin
      met = startLevel;
    end else if (cond < decode_pkg::COND_ALU_DONE) begin
      // six lines: three drain then three source; low tests then high
      off = cond - decode_pkg::COND_SC_BASE;
      if (off < 6'h06) begin
        met = !shortcutFeedback[off[2:0]];
      end else begin
        met = shortcutFeedback[3'(off - 6'h06)];
      end
    end else if (cond == decode_pkg::COND_ALU_DONE) begin
      met = aluDone;
    end else if (cond == decode_pkg::COND_BOOST_HIGH) begin
      met = boostHigh;
    end else if (cond == decode_pkg::COND_BOOST_LOW) begin
      met = !boostHigh;
    end else if (cond < decode_pkg::COND_CUR_LOW_BASE) begin
      off = cond - decode_pkg::COND_CUR_HIGH_BASE;
      met = currentFeedback[off[2:0]];
    end else if (cond < decode_pkg::COND_OWN_HIGH) begin
      off = cond - decode_pkg::COND_CUR_LOW_BASE;
      met = !currentFeedback[off[2:0]];
    end else if (cond == decode_pkg::COND_OWN_HIGH) begin
      met = ownCurrent;
    end else begin
      met = !ownCurrent;
    end
  end
endmodule

// file: bench/decode_asserts.sv
module decode_asserts #(
  parameter int REG_WIDTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // inputs
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  input wire logic [15:0] driveRight,
  input wire logic bootstrapLoad,
  input wire logic [REG_WIDTH-1:0] sourceData,
  input wire logic waitActive,
  // outputs
  input wire logic [47:0] thresholdLevels,
  input wire logic [4:0] sourceSelect,
  input wire logic [4:0] destSelect,
  input wire logic [REG_WIDTH-1:0] destData,
  input wire logic destWrite,
  input wire logic jumpTaken,
  input wire logic [4:0] rowEnabled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic isThr = instrValid && instrWord[15:7] == 9'h05f;
  wire logic isMove = instrValid && instrWord[15:13] == 3'h5
    && instrWord[2:0] == 3'h0;
  wire logic isFar = instrValid && instrWord[15:10] == 6'h04;
  property p_thr_set;
    logic [3:0] s;
    logic [2:0] l;
    (isThr && driveRight[instrWord[6:3]], s = instrWord[6:3],
      l = instrWord[2:0]) |=> thresholdLevels[s*3 +: 3] == l;
  endproperty
  a_thr_set: assert property (p_thr_set) else $error("level");
  property p_thr_hold;
    isThr && !driveRight[instrWord[6:3]] && !bootstrapLoad
      |=> $stable(thresholdLevels);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("right");
  property p_move_sel;
    isMove |=> sourceSelect == $past(instrWord[12:8])
      && destSelect == $past(instrWord[7:3]);
  endproperty
  a_move_sel: assert property (p_move_sel) else $error("sel");
  property p_move_wr;
    isMove |-> ##2 destWrite && destData == $past(sourceData);
  endproperty
  a_move_wr: assert property (p_move_wr) else $error("copy");
  property p_wr_cause;
    destWrite |-> $past(isMove, 2);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("stray");
  property p_row_set;
    logic [2:0] r;
    (isFar && instrWord[8:6] <= 3'h4, r = instrWord[8:6])
      |=> rowEnabled[r];
  endproperty
  a_row_set: assert property (p_row_set) else $error("row");
  property p_row_bad;
    isFar && instrWord[8:6] > 3'h4 |=> rowEnabled == $past(rowEnabled);
  endproperty
  a_row_bad: assert property (p_row_bad) else $error("bad row");
  property p_row_keep;
    1'b1 |=> (rowEnabled & $past(rowEnabled)) == $past(rowEnabled);
  endproperty
  a_row_keep: assert property (p_row_keep) else $error("lost");
  property p_jump;
    jumpTaken |-> $past(waitActive) && $past(rowEnabled) != 5'h00;
  endproperty
  a_jump: assert property (p_jump) else $error("jump");
  c_thr: cover property (isThr ##1 isThr);
  c_move: cover property (isMove ##2 destWrite);
  c_jump: cover property (jumpTaken);
endmodule

bind threshold_copy_waitentry_decode decode_asserts #(
  .REG_WIDTH(REG_WIDTH)
) i_chk (.sys_clk, .rst, .instrWord, .instrValid, .driveRight,
  .bootstrapLoad, .sourceData, .waitActive, .thresholdLevels, .sourceSelect,
  .destSelect, .destData, .destWrite, .jumpTaken, .rowEnabled);

// file: bench/code_memory.sv
module code_memory (
  // fetch
  input wire logic [5:0] addr,
  output logic [15:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  // first six hold with all status low, the rest only with all status high
  logic [5:0] conds [14] = '{6'h00, 6'h24, 6'h26, 6'h31, 6'h38, 6'h3f,
    6'h10, 6'h20, 6'h25, 6'h2c, 6'h2f, 6'h3e, 6'h32, 6'h30};
  initial begin
    for (int k = 0; k < 64; k++) mem[k] = 16'h0000;
    for (int k = 0; k < 16; k++) mem[k] = {9'h05f, 4'(k), 3'(k + 3)};
    mem[16] = {9'h05f, 4'h0, 3'h7};
    mem[17] = {3'h5, 5'h13, 5'h0a, 3'h0};
    mem[18] = {6'h04, 1'b0, 3'h5, 6'h00};
    mem[19] = {6'h04, 1'b1, 3'h1, 6'h13};
    for (int k = 0; k < 14; k++) begin
      mem[32 + k] = {6'h04, 1'b0, 3'h0, conds[k]};
    end
  end
  assign word = mem[addr];
endmodule

// file: bench/test_threshold_copy_waitentry_decode.sv
module test_threshold_copy_waitentry_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  logic [5:0] pc = 6'h00;
  logic [15:0] instrWord, destData;
  logic [15:0] driveRight = 16'hffff;
  logic bootstrapLoad = 1'b0;
  logic [4:0] bootstrapLevel = 5'h00;
  logic [15:0] sourceData = 16'h5a3c;
  logic [9:0] jumpPointerFirst = 10'h155;
  logic [9:0] jumpPointerSecond = 10'h2a6;
  logic waitActive = 1'b0;
  logic [15:0] flags = 16'h0000;
  logic aluDone = 1'b0;
  logic boostHigh = 1'b0;
  logic ownCurrent = 1'b0;
  logic [3:0] terminalCount = 4'h0;
  logic startPin = 1'b0;
  logic [5:0] shortcutFeedback = 6'h00;
  logic [5:0] currentFeedback = 6'h00;
  logic [47:0] thresholdLevels, thrExp;
  logic [4:0] sourceSelect, destSelect, rowEnabled;
  logic destWrite, jumpTaken;
  logic [9:0] jumpAddress;
  int fails = 0;
  int n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  code_memory i_mem (.addr(pc), .word(instrWord));
  threshold_copy_waitentry_decode i_dut (.sys_clk, .rst, .instrWord,
    .instrValid, .driveRight, .bootstrapLoad, .bootstrapLevel,
    .sourceData, .jumpPointerFirst, .jumpPointerSecond, .waitActive,
    .flags, .terminalCount, .startPin, .shortcutFeedback, .aluDone,
    .boostHigh, .currentFeedback, .ownCurrent, .thresholdLevels,
    .sourceSelect, .destSelect, .destData, .destWrite, .jumpTaken,
    .jumpAddress, .rowEnabled);
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // valid is held between words so back-to-back fetches never glitch it
  task automatic run(input logic [5:0] a);
    pc = a;
    instrValid = 1'b1;
    @(negedge sys_clk);
  endtask
  task automatic idle;
    instrValid = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic pulse_wait;
    waitActive = 1'b1;
    @(negedge sys_clk);
    waitActive = 1'b0;
  endtask
  task automatic set_status(input logic hi);
    flags = {16{hi}};
    terminalCount = {4{hi}};
    startPin = hi;
    shortcutFeedback = {6{hi}};
    aluDone = hi;
    boostHigh = hi;
    currentFeedback = {6{hi}};
    ownCurrent = hi;
  endtask
  task automatic thr_scn;
    thrExp = 48'h0;
    for (int k = 0; k < 16; k++) begin
      run(6'(k));
      thrExp[3*k +: 3] = 3'(k + 3);
      check(thresholdLevels, thrExp);
    end
    idle();
    driveRight = 16'hfffe;
    run(6'h10);
    idle();
    check(thresholdLevels, thrExp);
    bootstrapLevel = 5'h01;
    bootstrapLoad = 1'b1;
    @(negedge sys_clk);
    bootstrapLoad = 1'b0;
    thrExp[5:3] = 3'h0;
    check(thresholdLevels, thrExp);
  endtask
  task automatic move_scn;
    run(6'h11);
    check(48'(sourceSelect), 48'h13);
    check(48'(destSelect), 48'h0a);
    idle();
    check(48'({destWrite, destData}), 48'h15a3c);
    idle();
    check(48'(destWrite), 48'h0);
  endtask
  // second pass flips every status line, so each code must flip too
  task automatic cond_scn;
    logic hit;
    for (int p = 0; p < 2; p++) begin
      set_status(p[0]);
      for (int i = 0; i < 14; i++) begin
        run(6'(32 + i));
        idle();
        pulse_wait();
        hit = (i < 6) ^ p[0];
        check(48'(jumpTaken), 48'(hit));
        if (hit) check(48'(jumpAddress), 48'h155);
      end
    end
    set_status(1'b0);
  endtask
  task automatic row_scn;
    run(6'h12);
    idle();
    check(48'(rowEnabled), 48'h01);
    run(6'h13);
    idle();
    check(48'(rowEnabled), 48'h03);
    flags = 16'h0008;
    pulse_wait();
    check(48'({jumpTaken, jumpAddress}), 48'h6a6);
  endtask
  task automatic close_out;
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    close_out();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check(thresholdLevels, 48'h0);
    thr_scn();
    move_scn();
    cond_scn();
    row_scn();
    close_out();
  end
endmodule
